// *** rtl/dirt_debounce.sv ***
// pulse input filter: a new level must hold for LIMIT + 1 cycles when enabled
// assumes raw is already synchronised to mclk
`timescale 1ns/100ps
`include "dirt_defines.svh"

module dirt_debounce #(
    parameter int LIMIT = `DIRT_DEBOUNCE_CYCLES
) (
    // clock, reset, clock enable
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic ce,
    // filter port
    dirt_flt_if.flt   fl
);
    dirt_pkg::dirt_db_state_t state_r;
    dirt_pkg::dirt_db_state_t state_nxt;
    logic [31:0]              cnt_r;
    logic [31:0]              cnt_nxt;
    logic                     level_r;
    logic                     level_nxt;

    assign fl.level = level_r;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        level_nxt = level_r;
        if (ce) begin
            if (fl.debounce_on != `DIRT_DEB_ON) begin
                level_nxt = fl.raw;
                state_nxt = dirt_pkg::DB_STABLE;
                cnt_nxt   = '0;
            end else begin
                case (state_r)
                    dirt_pkg::DB_STABLE: begin
                        cnt_nxt = '0;
                        if (fl.raw != level_r) state_nxt = dirt_pkg::DB_SETTLING;
                    end
                    dirt_pkg::DB_SETTLING: begin
                        // short glitches, such as a 1 kHz train, fall back here
                        if (fl.raw == level_r) begin
                            state_nxt = dirt_pkg::DB_STABLE;
                        end else if (cnt_r == 32'(LIMIT - 1)) begin
                            level_nxt = fl.raw;
                            state_nxt = dirt_pkg::DB_STABLE;
                        end else begin
                            cnt_nxt = cnt_r + 32'h00000001;
                        end
                    end
                    default: state_nxt = dirt_pkg::DB_STABLE;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_r <= dirt_pkg::DB_STABLE;
            cnt_r   <= '0;
            level_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            level_r <= level_nxt;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    property p_db_hold;
        $past(fl.debounce_on) && $changed(level_r) |-> $past(cnt_r) == 32'(LIMIT - 1);
    endproperty
    a_db_hold: assert property (p_db_hold) else $error("filtered level changed early");
endmodule : dirt_debounce

// *** rtl/dirt_defines.svh ***
// constants for the digital line, relay and totalizer block
// assumes a 25 MHz system clock; included by the package, dirt_debounce and dirt_top
`ifndef DIRT_DEFINES_SVH
`define DIRT_DEFINES_SVH

`define DIRT_LINE_W            20
`define DIRT_RELAY_W           8
`define DIRT_COUNT_W           32
`define DIRT_LINE_ALL          20'hFFFFF
`define DIRT_RELAY_ALL         8'hFF
`define DIRT_LINE_DRIVE_RST    20'h00000
`define DIRT_RELAY_RST         8'h00
`define DIRT_COUNT_RST         32'h00000000
`define DIRT_COUNT_ONE         32'h00000001
`define DIRT_DIR_UP            1'b1
`define DIRT_DIR_DOWN          1'b0
`define DIRT_DIR_RST           1'b1
`define DIRT_DEB_ON            1'b1
`define DIRT_DEB_RST           1'b0
`define DIRT_CLK_MHZ           25
`define DIRT_DEBOUNCE_TIME_US  10000
`define DIRT_DEBOUNCE_CYCLES   (`DIRT_DEBOUNCE_TIME_US * `DIRT_CLK_MHZ)

`endif

// *** rtl/dirt_flt_if.sv ***
// carrier between the totalizer core and its input filter
// assumes both ends run on mclk
`timescale 1ns/100ps

interface dirt_flt_if;
    logic raw;
    logic debounce_on;
    logic level;
    modport src (output raw, output debounce_on, input level);
    modport flt (input raw, input debounce_on, output level);
endinterface : dirt_flt_if

// *** rtl/dirt_pkg.sv ***
// types shared by the digital line, relay and totalizer block
// assumes dirt_defines.svh sits on the include path
`include "dirt_defines.svh"

package dirt_pkg;
    typedef logic [`DIRT_LINE_W-1:0]  dirt_line_t;
    typedef logic [`DIRT_RELAY_W-1:0] dirt_relay_t;
    typedef logic [`DIRT_COUNT_W-1:0] dirt_count_t;
    typedef enum logic [0:0] {DB_STABLE, DB_SETTLING} dirt_db_state_t;
endpackage : dirt_pkg

// *** rtl/dirt_sync.sv ***
// two flip-flop synchroniser, one chain per bit
// assumes inputs are asynchronous to mclk; ce freezes both stages
`timescale 1ns/100ps

module dirt_sync #(
    parameter int W = 1
) (
    // clock, reset, clock enable
    input  wire logic         mclk,
    input  wire logic         reset,
    input  wire logic         ce,
    // data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] dout_nxt;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            // first stage feeds only the second stage
            always_comb begin
                meta_nxt[i] = ce ? din[i] : meta_r[i];
                dout_nxt[i] = ce ? meta_r[i] : dout[i];
            end
        end
    endgenerate

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            meta_r <= '0;
            dout   <= '0;
        end else begin
            meta_r <= meta_nxt;
            dout   <= dout_nxt;
        end
    end
endmodule : dirt_sync

// *** rtl/dirt_top.sv ***
// digital line, relay and totalizer block of the acquisition unit
// assumes a command parser on mclk presents one-cycle command strobes
`timescale 1ns/100ps
`include "dirt_defines.svh"

module dirt_top #(
    parameter int DEBOUNCE_CYCLES = `DIRT_DEBOUNCE_CYCLES
) (
    // clock, reset, clock enable
    input  wire logic          mclk,
    input  wire logic          reset,
    input  wire logic          ce,
    // line commands
    input  wire logic          line_write_cmd,
    input  dirt_pkg::dirt_line_t line_mask,
    input  dirt_pkg::dirt_line_t line_value,
    input  wire logic          line_readback_query,
    output dirt_pkg::dirt_line_t line_readback_data,
    output logic               line_readback_valid,
    // line pins, open drain
    input  dirt_pkg::dirt_line_t line_in,
    output dirt_pkg::dirt_line_t line_out,
    output dirt_pkg::dirt_line_t line_oe,
    output dirt_pkg::dirt_line_t line_level,
    // relays
    input  wire logic          relay_write_cmd,
    input  dirt_pkg::dirt_relay_t relay_mask,
    input  dirt_pkg::dirt_relay_t relay_value,
    output dirt_pkg::dirt_relay_t relay_closed,
    // totalizer commands
    input  wire logic          count_config_cmd,
    input  wire logic          cfg_direction,
    input  wire logic          cfg_debounce,
    input  wire logic          count_clear_cmd,
    input  wire logic          count_read_query,
    output dirt_pkg::dirt_count_t count_read_data,
    output logic               count_read_valid,
    // totalizer pins and status
    input  wire logic          count_pulse_in,
    input  wire logic          count_enable_in,
    output logic               count_dir_up,
    output logic               count_debounce_on,
    output logic               count_running
);
    function automatic dirt_pkg::dirt_line_t mask_merge(
        input dirt_pkg::dirt_line_t old_v,
        input dirt_pkg::dirt_line_t mask,
        input dirt_pkg::dirt_line_t val
    );
        return (old_v & ~mask) | (val & mask);
    endfunction : mask_merge

    // line and relay state
    dirt_pkg::dirt_line_t  drive_r;
    dirt_pkg::dirt_line_t  drive_nxt;
    dirt_pkg::dirt_line_t  rb_data_r;
    dirt_pkg::dirt_line_t  rb_data_nxt;
    logic                  rb_valid_r;
    logic                  rb_valid_nxt;
    dirt_pkg::dirt_relay_t relay_r;
    dirt_pkg::dirt_relay_t relay_nxt;
    dirt_pkg::dirt_line_t  relay_wide;

    // totalizer state
    dirt_pkg::dirt_count_t count_r;
    dirt_pkg::dirt_count_t count_nxt;
    dirt_pkg::dirt_count_t rd_data_r;
    dirt_pkg::dirt_count_t rd_data_nxt;
    logic                  rd_valid_r;
    logic                  rd_valid_nxt;
    logic                  dir_up_r;
    logic                  dir_up_nxt;
    logic                  deb_on_r;
    logic                  deb_on_nxt;
    logic                  filt_d_r;
    logic                  filt_d_nxt;
    logic [1:0]            cnt_pins_sync;
    logic                  enabled;
    logic                  rise;
    logic                  step;

    dirt_flt_if flt ();

    // the line pins only ever pull low; a released line floats high
    assign line_out            = '0;
    assign line_oe             = drive_r;
    assign line_readback_data  = rb_data_r;
    assign line_readback_valid = rb_valid_r;
    assign relay_closed        = relay_r;
    assign count_read_data     = rd_data_r;
    assign count_read_valid    = rd_valid_r;
    assign count_dir_up        = dir_up_r;
    assign count_debounce_on   = deb_on_r;
    assign count_running       = enabled;

    // input side of every line, usable whatever the line is driving
    dirt_sync #(.W(`DIRT_LINE_W)) u_line_sync (
        .mclk  (mclk),
        .reset (reset),
        .ce    (ce),
        .din   (line_in),
        .dout  (line_level)
    );

    dirt_sync #(.W(2)) u_cnt_sync (
        .mclk  (mclk),
        .reset (reset),
        .ce    (ce),
        .din   ({count_enable_in, count_pulse_in}),
        .dout  (cnt_pins_sync)
    );

    assign flt.raw         = cnt_pins_sync[0];
    assign flt.debounce_on = deb_on_r;

    dirt_debounce #(.LIMIT(DEBOUNCE_CYCLES)) u_deb (
        .mclk  (mclk),
        .reset (reset),
        .ce    (ce),
        .fl    (flt.flt)
    );

    // both gates must agree: line zero pulled low and the pin not grounded
    assign enabled = drive_r[0] & cnt_pins_sync[1];
    assign rise    = flt.level & ~filt_d_r;
    assign step    = ce & rise & enabled;

    // line and relay next state
    always_comb begin
        drive_nxt    = drive_r;
        rb_data_nxt  = rb_data_r;
        rb_valid_nxt = rb_valid_r;
        relay_nxt    = relay_r;
        relay_wide   = '0;
        if (ce) begin
            rb_valid_nxt = line_readback_query;
            if (line_write_cmd) begin
                // bit n of the value steers line n; drive is the inverse
                drive_nxt = mask_merge(drive_r, line_mask, ~line_value);
            end
            if (line_readback_query) begin
                rb_data_nxt = ~drive_r;
            end
            if (relay_write_cmd) begin
                relay_wide = mask_merge({12'h000, relay_r}, {12'h000, relay_mask},
                                        {12'h000, ~relay_value});
                relay_nxt  = relay_wide[`DIRT_RELAY_W-1:0];
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            drive_r    <= `DIRT_LINE_DRIVE_RST;
            rb_data_r  <= '0;
            rb_valid_r <= 1'b0;
            relay_r    <= `DIRT_RELAY_RST;
        end else begin
            drive_r    <= drive_nxt;
            rb_data_r  <= rb_data_nxt;
            rb_valid_r <= rb_valid_nxt;
            relay_r    <= relay_nxt;
        end
    end

    // totalizer next state
    always_comb begin
        count_nxt    = count_r;
        rd_data_nxt  = rd_data_r;
        rd_valid_nxt = rd_valid_r;
        dir_up_nxt   = dir_up_r;
        deb_on_nxt   = deb_on_r;
        filt_d_nxt   = filt_d_r;
        if (ce) begin
            filt_d_nxt   = flt.level;
            rd_valid_nxt = count_read_query;
            if (count_read_query) begin
                rd_data_nxt = count_r;
            end
            if (count_config_cmd) begin
                dir_up_nxt = cfg_direction;
                deb_on_nxt = cfg_debounce;
            end
            // a clear beats a pulse arriving in the same cycle
            if (count_clear_cmd) begin
                count_nxt = `DIRT_COUNT_RST;
            end else if (step) begin
                if (dir_up_r == `DIRT_DIR_UP) begin
                    count_nxt = count_r + `DIRT_COUNT_ONE;
                end else begin
                    count_nxt = count_r - `DIRT_COUNT_ONE;
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            count_r    <= `DIRT_COUNT_RST;
            rd_data_r  <= '0;
            rd_valid_r <= 1'b0;
            dir_up_r   <= `DIRT_DIR_RST;
            deb_on_r   <= `DIRT_DEB_RST;
            filt_d_r   <= 1'b0;
        end else begin
            count_r    <= count_nxt;
            rd_data_r  <= rd_data_nxt;
            rd_valid_r <= rd_valid_nxt;
            dir_up_r   <= dir_up_nxt;
            deb_on_r   <= deb_on_nxt;
            filt_d_r   <= filt_d_nxt;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    property p_line_merge;
        ce && line_write_cmd |=> (~drive_r & $past(line_mask)) == ($past(line_value) & $past(line_mask))
                                 && (drive_r & ~$past(line_mask)) == ($past(drive_r) & ~$past(line_mask));
    endproperty
    a_line_merge: assert property (p_line_merge) else $error("line write merge wrong");

    property p_line_bit;
        ce && line_write_cmd && line_mask[0] |=> line_oe[0] == !$past(line_value[0]);
    endproperty
    a_line_bit: assert property (p_line_bit) else $error("line zero not steered by bit zero");

    property p_line_pin;
        ce && line_write_cmd |=> line_out == '0 && (line_oe & $past(line_mask & line_value)) == '0
                                 && (~line_oe & $past(line_mask & ~line_value)) == '0;
    endproperty
    a_line_pin: assert property (p_line_pin) else $error("line pin drive wrong");

    property p_readback;
        ce && line_readback_query |=> line_readback_valid && line_readback_data == ~$past(line_oe);
    endproperty
    a_readback: assert property (p_readback) else $error("readback mismatch");

    property p_relay;
        ce && relay_write_cmd |=> ((relay_closed ^ ~$past(relay_value)) & $past(relay_mask)) == '0
                                  && (relay_closed & ~$past(relay_mask)) == ($past(relay_closed) & ~$past(relay_mask));
    endproperty
    a_relay: assert property (p_relay) else $error("relay write wrong");

    property p_config;
        ce && count_config_cmd |=> count_dir_up == $past(cfg_direction) && count_debounce_on == $past(cfg_debounce);
    endproperty
    a_config: assert property (p_config) else $error("counter config not taken");

    property p_clear_read;
        ce && count_clear_cmd ##1 ce && count_read_query |=> count_read_valid && count_read_data == '0;
    endproperty
    a_clear_read: assert property (p_clear_read) else $error("read after clear not zero");

    property p_count_up;
        step && count_dir_up && !count_clear_cmd |=> count_r == $past(count_r) + `DIRT_COUNT_ONE;
    endproperty
    a_count_up: assert property (p_count_up) else $error("up count step wrong");

    property p_hold;
        (!enabled || !ce) && !count_clear_cmd |=> count_r == $past(count_r);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved while disabled");

    property p_wrap;
        step && !count_dir_up && !count_clear_cmd && count_r == '0 |=> count_r == {`DIRT_COUNT_W{1'b1}};
    endproperty
    a_wrap: assert property (p_wrap) else $error("down count did not wrap");

    property p_one_per_edge;
        step |=> !step;
    endproperty
    a_one_per_edge: assert property (p_one_per_edge) else $error("two counts from one edge");

    c_count_up: cover property (step && count_dir_up);
    c_wrap: cover property (step && !count_dir_up && count_r == '0);
    c_clear_read: cover property (ce && count_clear_cmd ##1 ce && count_read_query);
    c_relay_all: cover property (ce && relay_write_cmd && relay_mask == `DIRT_RELAY_ALL);
endmodule : dirt_top

// *** verification/dirt_pin_model.sv ***
// far-side pin environment: pulled-up open-drain lines, an external short, a pulse source
// assumes pulse_train is called just after a rising mclk edge
`timescale 1ns/100ps

module dirt_pin_model (
    // clock
    input  wire logic            mclk,
    // line pins
    input  dirt_pkg::dirt_line_t line_out,
    input  dirt_pkg::dirt_line_t line_oe,
    input  dirt_pkg::dirt_line_t ext_low,
    output dirt_pkg::dirt_line_t line_in,
    // totalizer pin
    output logic                 count_pulse_in
);
    // a released line goes to the pull-up unless ext_low shorts it, never to its last driven value
    assign line_in = (line_out | ~line_oe) & ~ext_low;

    initial count_pulse_in = 1'b0;

    // generator pulses; half period in mclk cycles, at least 1 with filtering off
    task pulse_train(input int n, input int half);
        repeat (n) begin
            count_pulse_in <= 1'b1;
            repeat (half) @(posedge mclk);
            count_pulse_in <= 1'b0;
            repeat (half) @(posedge mclk);
        end
    endtask : pulse_train
endmodule : dirt_pin_model

// *** verification/tb_dirt_top.sv ***
// self-checking bench for the digital line, relay and totalizer block
// assumes the pin model beside it; debounce shortened to DEB cycles
`timescale 1ns/100ps

module tb_dirt_top;
    localparam int DEB = 12;
    logic                  mclk, reset, ce;
    logic                  line_write_cmd, line_readback_query, relay_write_cmd;
    logic                  count_config_cmd, cfg_direction, cfg_debounce, count_clear_cmd, count_read_query;
    logic                  count_enable_in, count_pulse_in, line_readback_valid, count_read_valid;
    logic                  count_dir_up, count_debounce_on, count_running;
    dirt_pkg::dirt_line_t  line_mask, line_value, line_readback_data, line_in, line_out, line_oe;
    dirt_pkg::dirt_line_t  line_level, ext_low;
    dirt_pkg::dirt_relay_t relay_mask, relay_value, relay_closed;
    dirt_pkg::dirt_count_t count_read_data, got;
    int                    err_count, check_count;
    dirt_pkg::dirt_line_t  vals [3] = '{20'h00001, 20'h00080, 20'h80000};

    initial mclk = 1'b0;
    always #20 mclk = ~mclk;

    dirt_top #(.DEBOUNCE_CYCLES(DEB)) dirt_top_i (
        .mclk(mclk), .reset(reset), .ce(ce),
        .line_write_cmd(line_write_cmd), .line_mask(line_mask), .line_value(line_value),
        .line_readback_query(line_readback_query), .line_readback_data(line_readback_data),
        .line_readback_valid(line_readback_valid), .line_in(line_in), .line_out(line_out),
        .line_oe(line_oe), .line_level(line_level), .relay_write_cmd(relay_write_cmd),
        .relay_mask(relay_mask), .relay_value(relay_value), .relay_closed(relay_closed),
        .count_config_cmd(count_config_cmd), .cfg_direction(cfg_direction), .cfg_debounce(cfg_debounce),
        .count_clear_cmd(count_clear_cmd), .count_read_query(count_read_query),
        .count_read_data(count_read_data), .count_read_valid(count_read_valid),
        .count_pulse_in(count_pulse_in), .count_enable_in(count_enable_in), .count_dir_up(count_dir_up),
        .count_debounce_on(count_debounce_on), .count_running(count_running)
    );

    dirt_pin_model dirt_pin_model_i (
        .mclk(mclk), .line_out(line_out), .line_oe(line_oe), .ext_low(ext_low),
        .line_in(line_in), .count_pulse_in(count_pulse_in)
    );

    task end_sim;
        if (err_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    task chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // one-cycle strobe; the idle cycle after it keeps strobes from colliding
    task cmd(input int sel);
        case (sel)
            0: line_write_cmd <= 1'b1;
            1: relay_write_cmd <= 1'b1;
            2: count_config_cmd <= 1'b1;
            default: count_clear_cmd <= 1'b1;
        endcase
        @(posedge mclk);
        {line_write_cmd, relay_write_cmd, count_config_cmd, count_clear_cmd} <= 4'h0;
        @(posedge mclk);
    endtask : cmd

    // query then sample data with its valid pulse one cycle later
    task rd(input int sel, output dirt_pkg::dirt_count_t v);
        if (sel == 0) line_readback_query <= 1'b1;
        else count_read_query <= 1'b1;
        @(posedge mclk);
        line_readback_query <= 1'b0;
        count_read_query <= 1'b0;
        #1;
        v = (sel == 0) ? {12'h000, line_readback_data} : count_read_data;
        chk("read_valid", 32'h00000001, {31'h0, (sel == 0) ? line_readback_valid : count_read_valid});
        @(posedge mclk);
    endtask : rd

    // a hang is cut short here
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        end_sim;
    end

    initial begin
        err_count = 0;
        check_count = 0;
        reset = 1'b1;
        ce = 1'b1;
        {line_write_cmd, line_readback_query, relay_write_cmd, count_config_cmd} = 4'h0;
        {count_clear_cmd, count_read_query, cfg_direction, cfg_debounce, count_enable_in} = 5'h00;
        line_mask = 20'h00000;
        line_value = 20'h00000;
        ext_low = 20'h00000;
        relay_mask = 8'h00;
        relay_value = 8'h00;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        chk("line_oe", 32'h00000000, line_oe);
        chk("line_out", 32'h00000000, line_out);
        chk("relay_closed", 32'h00000000, relay_closed);
        // all lines released, then one shorted outside: input path sees it, readback does not
        line_mask <= 20'hFFFFF;
        line_value <= 20'hFFFFF;
        cmd(0);
        ext_low <= 20'h00020;
        repeat (4) @(posedge mclk);
        chk("line_level", 32'h000FFFDF, line_level);
        rd(0, got);
        chk("line_readback", 32'h000FFFFF, got);
        ext_low <= 20'h00000;
        foreach (vals[i]) begin
            line_value <= vals[i];
            cmd(0);
            chk("line_oe", 32'h000FFFFF, line_oe ^ vals[i]);
            rd(0, got);
            chk("line_readback", vals[i], got);
            line_value <= 20'h00000;
            cmd(0);
            rd(0, got);
            chk("line_readback", 32'h00000000, got);
        end
        repeat (3) @(posedge mclk);
        chk("line_level", 32'h00000000, line_level);
        // the host always sends a full relay mask
        relay_mask <= 8'hFF;
        for (int k = 0; k < 8; k++) begin
            relay_value <= ~(8'h01 << k);
            cmd(1);
            chk("relay_closed", 8'h01 << k, relay_closed);
        end
        relay_value <= 8'hFF;
        cmd(1);
        chk("relay_closed", 32'h00000000, relay_closed);
        // a strobe with the clock enable low is ignored
        ce <= 1'b0;
        relay_value <= 8'h00;
        cmd(1);
        ce <= 1'b1;
        chk("relay_closed", 32'h00000000, relay_closed);
        // totalizer counting up, filter off
        count_enable_in <= 1'b1;
        cfg_direction <= 1'b1;
        cmd(2);
        chk("count_dir_up", 32'h00000001, count_dir_up);
        chk("count_debounce_on", 32'h00000000, count_debounce_on);
        cmd(3);
        rd(1, got);
        chk("count", 32'h00000000, got);
        chk("count_running", 32'h00000001, count_running);
        dirt_pin_model_i.pulse_train(5, 4);
        repeat (4) @(posedge mclk);
        rd(1, got);
        chk("count", 32'h00000005, got);
        // line zero alone written high: others keep their state, counting stops
        line_mask <= 20'h00001;
        line_value <= 20'h00001;
        cmd(0);
        chk("line_oe", 32'h000FFFFE, line_oe);
        chk("count_running", 32'h00000000, count_running);
        dirt_pin_model_i.pulse_train(3, 4);
        rd(1, got);
        chk("count", 32'h00000005, got);
        line_value <= 20'h00000;
        cmd(0);
        count_enable_in <= 1'b0;
        repeat (3) @(posedge mclk);
        dirt_pin_model_i.pulse_train(3, 4);
        rd(1, got);
        chk("count", 32'h00000005, got);
        // down from zero wraps
        count_enable_in <= 1'b1;
        cfg_direction <= 1'b0;
        cmd(2);
        chk("count_dir_up", 32'h00000000, count_dir_up);
        cmd(3);
        dirt_pin_model_i.pulse_train(2, 4);
        repeat (4) @(posedge mclk);
        rd(1, got);
        chk("count", 32'hFFFFFFFE, got);
        // filter on: a fast train leaves at most one count, a long pulse counts once
        cfg_direction <= 1'b1;
        cfg_debounce <= 1'b1;
        cmd(2);
        chk("count_debounce_on", 32'h00000001, count_debounce_on);
        cmd(3);
        dirt_pin_model_i.pulse_train(10, DEB / 2);
        repeat (4 * DEB) @(posedge mclk);
        rd(1, got);
        chk("count_drift", 32'h00000001, {31'h0, got <= 32'h00000001});
        cmd(3);
        dirt_pin_model_i.pulse_train(1, DEB * 3);
        repeat (4) @(posedge mclk);
        rd(1, got);
        chk("count", 32'h00000001, got);
        end_sim;
    end
endmodule : tb_dirt_top
